// ===== hib_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "hib_seq_map.svh"
module hib_sequencer
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  hib_link_if.sequencer link,
  input wire logic [`SEQ_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out
);
  import hib_seq_pkg::*;

  seq_state_e state_r;
  word_t tmo_r;
  logic [15:0] clrlen_r;
  word_t cnt_r;
  logic ready_r;
  logic fail_r;
  logic hold_init_r;
  logic [1:0] rail_step_r;
  logic go_enter;
  logic go_exit;
  logic go_quiesce;
  logic go_restart;
  logic go_brown;

  function automatic logic ctrl_bit(input int unsigned pos);
    ctrl_bit = wr_in && addr_in == `SEQ_CTRL_ADDR && wdata_in[pos];
  endfunction

  assign go_enter = ctrl_bit(`CTRL_HIB_ENTER);
  assign go_exit = ctrl_bit(`CTRL_HIB_EXIT);
  assign go_quiesce = ctrl_bit(`CTRL_QUIESCE);
  assign go_restart = ctrl_bit(`CTRL_RESTART);
  assign go_brown = ctrl_bit(`CTRL_BROWNOUT);

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      tmo_r <= `TMO_RESET;
      clrlen_r <= `CLRLEN_RESET;
      hold_init_r <= 1'b0;
    end
    else if (wr_in)
    begin
      if (addr_in == `SEQ_TMO_ADDR)
        tmo_r <= wdata_in;
      if (addr_in == `SEQ_CLRLEN_ADDR)
        clrlen_r <= wdata_in[15:0];
      if (addr_in == `SEQ_CTRL_ADDR)
        hold_init_r <= wdata_in[`CTRL_HOLD_INIT];
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= SQ_WAIT_INIT;
      cnt_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      fail_r <= 1'b0;
      rail_step_r <= 2'b00;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h0000_0001;
      unique case (state_r)
        SQ_IDLE:
        begin
          cnt_r <= 32'h0000_0000;
          if (go_enter || go_quiesce || go_brown)
          begin
            state_r <= SQ_CLEAR;
            ready_r <= 1'b0;
            fail_r <= 1'b0;
            rail_step_r <= go_enter ? 2'b01 : (go_quiesce ? 2'b10 : 2'b00);
          end
        end
        SQ_CLEAR:
        begin
          if (cnt_r >= {16'h0000, clrlen_r})
          begin
            cnt_r <= 32'h0000_0000;
            if (rail_step_r == 2'b01)
            begin
              state_r <= SQ_RAILS_OFF;
              rail_step_r <= 2'b00;
            end
            else if (rail_step_r == 2'b10)
              state_r <= SQ_QUIET;
            else
              state_r <= SQ_WAIT_INIT;
          end
        end
        SQ_QUIET:
        begin
          cnt_r <= 32'h0000_0000;
          if (go_restart)
            state_r <= SQ_WAIT_INIT;
        end
        SQ_RAILS_OFF:
        begin
          cnt_r <= 32'h0000_0000;
          if (rail_step_r == 2'b10)
            state_r <= SQ_HIBERNATE;
          else
            rail_step_r <= rail_step_r + 2'b01;
        end
        SQ_HIBERNATE:
        begin
          cnt_r <= 32'h0000_0000;
          if (go_exit)
            rail_step_r <= 2'b11;
          if (rail_step_r == 2'b11 && link.core_supply_on)
            state_r <= SQ_WAIT_INIT;
        end
        SQ_WAIT_INIT:
        begin
          if (link.init_n)
          begin
            state_r <= SQ_WAIT_DONE;
            cnt_r <= 32'h0000_0000;
          end
          else if (cnt_r >= tmo_r)
          begin
            fail_r <= 1'b1;
            state_r <= SQ_IDLE;
          end
        end
        SQ_WAIT_DONE:
        begin
          if (link.done)
          begin
            ready_r <= 1'b1;
            state_r <= SQ_IDLE;
          end
          else if (cnt_r >= tmo_r)
          begin
            fail_r <= 1'b1;
            state_r <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  // Pins toward the device
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      link.config_clear_n <= 1'b1;
      link.pullup_disable_in <= 1'b0;
      link.init_n_seq_out <= 1'b0;
      link.init_n_seq_oe <= 1'b0;
      link.core_supply_on <= 1'b1;
      link.aux_supply_on <= 1'b1;
      link.output_supply_on <= 1'b1;
      link.slave_mode <= 1'b0;
      link.config_serial_clock_en <= 1'b1;
    end
    else
    begin
      if (state_r == SQ_IDLE && (go_enter || go_quiesce || go_brown))
        link.config_clear_n <= 1'b0;
      else if (state_r == SQ_CLEAR && cnt_r >= {16'h0000, clrlen_r} && rail_step_r != 2'b01)
        link.config_clear_n <= 1'b1;
      else if (state_r == SQ_HIBERNATE && rail_step_r == 2'b11 && link.core_supply_on)
        link.config_clear_n <= 1'b1;
      if (state_r == SQ_IDLE && (go_enter || go_quiesce || go_brown))
        link.pullup_disable_in <= 1'b1;
      else if ((state_r == SQ_QUIET && go_restart)
        || (state_r == SQ_HIBERNATE && rail_step_r == 2'b11 && link.core_supply_on))
        link.pullup_disable_in <= 1'b0;
      link.init_n_seq_oe <= (state_r == SQ_QUIET) && hold_init_r;
      link.config_serial_clock_en <= !(state_r == SQ_QUIET && !hold_init_r);
      link.slave_mode <= (state_r == SQ_QUIET) && !hold_init_r;
      if (state_r == SQ_RAILS_OFF)
      begin
        unique case (rail_step_r)
          2'b00: link.output_supply_on <= 1'b0;
          2'b01: link.aux_supply_on <= 1'b0;
          default: link.core_supply_on <= 1'b0;
        endcase
      end
      if (state_r == SQ_HIBERNATE && rail_step_r == 2'b11)
      begin
        link.output_supply_on <= 1'b1;
        link.aux_supply_on <= 1'b1;
        link.core_supply_on <= link.output_supply_on && link.aux_supply_on;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
    begin
      unique case (addr_in)
        `SEQ_STAT_ADDR: rdata_out <= {27'h000_0000, state_r != SQ_IDLE && state_r != SQ_QUIET
          && state_r != SQ_HIBERNATE, state_r == SQ_QUIET, state_r == SQ_HIBERNATE, fail_r, ready_r};
        `SEQ_CTRL_ADDR: rdata_out <= {27'h000_0000, hold_init_r, 4'h0};
        `SEQ_TMO_ADDR: rdata_out <= tmo_r;
        `SEQ_CLRLEN_ADDR: rdata_out <= {16'h0000, clrlen_r};
        default: rdata_out <= 32'h0000_0000;
      endcase
    end
    else
      rdata_out <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// ===== hib_seq_map.svh
`ifndef HIB_SEQ_MAP_SVH
`define HIB_SEQ_MAP_SVH

// Software port of the sequencer
`define SEQ_ADDR_W 4
`define SEQ_CTRL_ADDR 4'h0
`define SEQ_STAT_ADDR 4'h1
`define SEQ_TMO_ADDR 4'h2
`define SEQ_CLRLEN_ADDR 4'h3

// Control bits
`define CTRL_HIB_ENTER 0
`define CTRL_HIB_EXIT 1
`define CTRL_QUIESCE 2
`define CTRL_RESTART 3
`define CTRL_HOLD_INIT 4
`define CTRL_BROWNOUT 5

// Status bits
`define STAT_READY 0
`define STAT_FAIL 1
`define STAT_HIBERNATE 2
`define STAT_QUIET 3
`define STAT_BUSY 4

// Reset values of the timing registers
`define TMO_RESET 32'h000F_4240
`define CLRLEN_RESET 16'h0064

// Device side timing, in sys_clk_in cycles; POR delay and clock period given in ns
`define POR_DELAY_NS 1000
`define CLK_PERIOD_NS 10
`define POR_DELAY_CYC ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CLEAR_CYC 16
`define CONFIG_LOAD_CYC 64

`endif

// ===== hib_seq_pkg.sv
`default_nettype none
package hib_seq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0] addr_t;

  typedef enum logic [6:0]
  {
    SQ_IDLE = 7'b000_0001,
    SQ_CLEAR = 7'b000_0010,
    SQ_WAIT_INIT = 7'b000_0100,
    SQ_QUIET = 7'b000_1000,
    SQ_RAILS_OFF = 7'b001_0000,
    SQ_HIBERNATE = 7'b010_0000,
    SQ_WAIT_DONE = 7'b100_0000
  } seq_state_e;

  typedef enum logic [4:0]
  {
    DV_RESET = 5'b0_0001,
    DV_INIT = 5'b0_0010,
    DV_WAIT_INIT = 5'b0_0100,
    DV_CONFIG = 5'b0_1000,
    DV_USER = 5'b1_0000
  } dev_state_e;
endpackage
`default_nettype wire

// ===== hib_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hib_link_if;
  logic config_clear_n;
  logic pullup_disable_in;
  logic init_n_dev_out;
  logic init_n_dev_oe;
  logic init_n_seq_out;
  logic init_n_seq_oe;
  logic done;
  logic core_supply_on;
  logic aux_supply_on;
  logic output_supply_on;
  logic slave_mode;
  logic config_serial_clock_en;
  // Open-drain wire level: low if any end drives low
  logic init_n;
  assign init_n = !((init_n_dev_oe && !init_n_dev_out) || (init_n_seq_oe && !init_n_seq_out));

  modport device
  (
    input config_clear_n, pullup_disable_in, init_n, core_supply_on, aux_supply_on,
    input output_supply_on, slave_mode, config_serial_clock_en,
    output init_n_dev_out, init_n_dev_oe, done
  );
  modport sequencer
  (
    input init_n, done,
    output config_clear_n, pullup_disable_in, init_n_seq_out, init_n_seq_oe,
    output core_supply_on, aux_supply_on, output_supply_on, slave_mode, config_serial_clock_en
  );
endinterface
`default_nettype wire

// ===== hib_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "hib_seq_map.svh"
module hib_device
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  hib_link_if.device link,
  output logic io_enable_out,
  output logic switching_out,
  output logic config_valid_out,
  output logic user_ready_out
);
  import hib_seq_pkg::*;

  dev_state_e state_r;
  logic [15:0] cnt_r;
  logic cfg_valid_r;
  logic powered;
  // Output rail no longer watched once configured
  assign powered = link.core_supply_on && link.aux_supply_on && (link.output_supply_on || cfg_valid_r);

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !powered || !link.config_clear_n)
    begin
      state_r <= (sys_rst_in || !powered) ? DV_RESET : DV_INIT;
      cnt_r <= 16'h0000;
    end
    else
    begin
      unique case (state_r)
        DV_RESET:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= 16'(`POR_DELAY_CYC))
          begin
            state_r <= DV_INIT;
            cnt_r <= 16'h0000;
          end
        end
        DV_INIT:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= 16'(`INIT_CLEAR_CYC))
          begin
            state_r <= DV_WAIT_INIT;
            cnt_r <= 16'h0000;
          end
        end
        DV_WAIT_INIT:
        begin
          if (link.init_n)
            state_r <= DV_CONFIG;
        end
        DV_CONFIG:
        begin
          if (link.slave_mode && !link.config_serial_clock_en)
            cnt_r <= cnt_r;
          else
            cnt_r <= cnt_r + 16'h0001;
          if (cnt_r >= 16'(`CONFIG_LOAD_CYC))
            state_r <= DV_USER;
        end
        DV_USER:
          state_r <= DV_USER;
      endcase
    end
  end

  // Configuration memory cleared while clear is low or power gone
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in || !powered || !link.config_clear_n)
      cfg_valid_r <= 1'b0;
    else if (state_r == DV_CONFIG && cnt_r >= 16'(`CONFIG_LOAD_CYC))
      cfg_valid_r <= 1'b1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      link.init_n_dev_out <= 1'b0;
      link.init_n_dev_oe <= 1'b1;
      link.done <= 1'b0;
      io_enable_out <= 1'b0;
      switching_out <= 1'b0;
      config_valid_out <= 1'b0;
      user_ready_out <= 1'b0;
    end
    else
    begin
      link.init_n_dev_out <= 1'b0;
      link.init_n_dev_oe <= !link.config_clear_n || !powered || state_r == DV_RESET
        || state_r == DV_INIT;
      link.done <= link.config_clear_n && powered && state_r == DV_USER;
      io_enable_out <= link.config_clear_n && powered && state_r == DV_USER;
      switching_out <= link.config_clear_n && powered && state_r == DV_USER;
      config_valid_out <= cfg_valid_r;
      user_ready_out <= link.config_clear_n && powered && state_r == DV_USER;
    end
  end
endmodule
`default_nettype wire

// ===== hib_seq_checker.sv
`timescale 1ns/10ps
`default_nettype none
module hib_seq_checker
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic config_clear_n,
  input wire logic pullup_disable_in,
  input wire logic init_n,
  input wire logic done,
  input wire logic core_supply_on,
  input wire logic aux_supply_on,
  input wire logic output_supply_on
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Hibernate entry steps and init release
  sequence out_off;
    $fell(output_supply_on);
  endsequence
  sequence aux_then_core;
    $fell(aux_supply_on) ##1 $fell(core_supply_on);
  endsequence
  sequence init_up;
    $rose(init_n);
  endsequence
  AST_CLEAR_RESP: assert property ($fell(config_clear_n) |=> !init_n && !done)
    else $error("init or done high after clear fell");
  AST_CLEAR_HOLD: assert property (!config_clear_n && core_supply_on && aux_supply_on |=> !init_n)
    else $error("init released while clear held");
  AST_PULLUP_OFF: assert property (!config_clear_n |-> pullup_disable_in)
    else $error("pull-ups enabled during clear");
  AST_RAIL_STEPS: assert property (out_off |-> !config_clear_n ##1 aux_then_core)
    else $error("rails not switched off in order");
  AST_AUX_ORDER: assert property ($fell(aux_supply_on) |-> !output_supply_on)
    else $error("aux rail off before output rail");
  AST_HOLD_CLEAR: assert property (!(core_supply_on && aux_supply_on && output_supply_on) |-> !config_clear_n)
    else $error("clear released while a rail is off");
  AST_CLEAR_RISE: assert property ($rose(config_clear_n) |->
    core_supply_on && aux_supply_on && output_supply_on)
    else $error("clear rose before all rails on");
  AST_CONF_WAIT: assert property (init_up |-> !done [*8])
    else $error("done rose too soon after init");
  AST_DONE_RAILS: assert property (done |-> core_supply_on && aux_supply_on && output_supply_on)
    else $error("done high with a rail off");
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "hib_seq_map.svh"
module tb;
  import hib_seq_pkg::*;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  addr_t addr = 4'h0;
  word_t wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  word_t rdata;
  word_t v;
  logic io_en, sw, cfg_ok, uready;
  int fail_count = 0;
  int num_checks = 0;
  hib_link_if link ();
  hib_sequencer hib_sequencer_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(link),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
  hib_device hib_device_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(link),
    .io_enable_out(io_en), .switching_out(sw), .config_valid_out(cfg_ok), .user_ready_out(uready));
  hib_seq_checker hib_seq_checker_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .config_clear_n(link.config_clear_n), .pullup_disable_in(link.pullup_disable_in),
    .init_n(link.init_n), .done(link.done), .core_supply_on(link.core_supply_on),
    .aux_supply_on(link.aux_supply_on), .output_supply_on(link.output_supply_on));
  always #5 sys_clk_in = ~sys_clk_in;
  task automatic check(string name, word_t seen, word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(addr_t a, word_t d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(addr_t a, output word_t d);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_stat(int b, logic e);
    int n;
    n = 0;
    rd_reg(`SEQ_STAT_ADDR, v);
    while (v[b] !== e && n < 400)
    begin
      rd_reg(`SEQ_STAT_ADDR, v);
      n++;
    end
    check("status bit", word_t'(v[b]), word_t'(e));
  endtask
  // Device configured and sequencer reports ready
  task automatic ready_ok(string name);
    wait_stat(`STAT_READY, 1'b1);
    check("fail bit", word_t'(v[`STAT_FAIL]), 0);
    check("done", link.done, 1);
    check("init", link.init_n, 1);
    check("io enable", io_en, 1);
    check("user ready", uready, 1);
    check("config valid", cfg_ok, 1);
    check("clear", link.config_clear_n, 1);
    check("rails", {link.core_supply_on, link.aux_supply_on, link.output_supply_on}, 32'h0000_0007);
    $display("test %s done", name);
  endtask
  task automatic t_regs();
    rd_reg(`SEQ_TMO_ADDR, v);
    check("timeout reset", v, `TMO_RESET);
    rd_reg(`SEQ_CLRLEN_ADDR, v);
    check("clear length reset", v, word_t'(`CLRLEN_RESET));
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rd_reg(4'hF, v);
    check("unmapped", v, 32'h0000_0000);
    wr_reg(`SEQ_CLRLEN_ADDR, 32'h0000_0008);
    rd_reg(`SEQ_CLRLEN_ADDR, v);
    check("clear length", v, 32'h0000_0008);
    $display("test regs done");
  endtask
  task automatic t_hib();
    wr_reg(`SEQ_CTRL_ADDR, word_t'(1 << `CTRL_HIB_ENTER));
    repeat (2) @(posedge sys_clk_in);
    #1;
    check("clear", link.config_clear_n, 0);
    check("pullup off", link.pullup_disable_in, 1);
    check("done", link.done, 0);
    check("init", link.init_n, 0);
    check("io enable", io_en, 0);
    check("switching", sw, 0);
    wait_stat(`STAT_HIBERNATE, 1'b1);
    check("rails", {link.core_supply_on, link.aux_supply_on, link.output_supply_on}, 0);
    check("clear", link.config_clear_n, 0);
    check("pullup off", link.pullup_disable_in, 1);
    check("config valid", cfg_ok, 0);
    wr_reg(`SEQ_CTRL_ADDR, word_t'(1 << `CTRL_HIB_EXIT));
    ready_ok("hibernate");
    check("pullup on", link.pullup_disable_in, 0);
  endtask
  task automatic t_quiet();
    for (int m = 0; m < 2; m++)
    begin
      wr_reg(`SEQ_CTRL_ADDR, word_t'((1 << `CTRL_QUIESCE) | (m << `CTRL_HOLD_INIT)));
      wait_stat(`STAT_QUIET, 1'b1);
      check("clear", link.config_clear_n, 1);
      check("done", link.done, 0);
      check("pullup off", link.pullup_disable_in, 1);
      if (m == 1)
        check("init", link.init_n, 0);
      else
        check("clock en", {link.slave_mode, link.config_serial_clock_en}, 32'h0000_0002);
      wr_reg(`SEQ_CTRL_ADDR, word_t'(1 << `CTRL_RESTART));
      ready_ok("quiesce");
      check("clock en", link.config_serial_clock_en, 1);
    end
  endtask
  task automatic t_brown();
    wr_reg(`SEQ_CTRL_ADDR, word_t'(1 << `CTRL_BROWNOUT));
    repeat (2) @(posedge sys_clk_in);
    #1;
    check("clear", link.config_clear_n, 0);
    check("done", link.done, 0);
    check("pullup off", link.pullup_disable_in, 1);
    rd_reg(`SEQ_STAT_ADDR, v);
    check("busy bit", word_t'(v[`STAT_BUSY]), 1);
    ready_ok("brownout");
  endtask
  // Short timeout expires while the device still holds init low
  task automatic t_tmo();
    wr_reg(`SEQ_TMO_ADDR, 32'h0000_0008);
    wr_reg(`SEQ_CTRL_ADDR, word_t'(1 << `CTRL_BROWNOUT));
    wait_stat(`STAT_FAIL, 1'b1);
    check("ready bit", word_t'(v[`STAT_READY]), 0);
    wr_reg(`SEQ_TMO_ADDR, `TMO_RESET);
    rd_reg(`SEQ_TMO_ADDR, v);
    check("timeout", v, `TMO_RESET);
    $display("test timeout done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    ready_ok("power up");
    t_regs();
    t_hib();
    t_quiet();
    t_tmo();
    t_brown();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
